// ---- verilog/dsos_cfg.svh ----
// constants and register map for the drive status output selector
// Notes on behaviour
// - codes 0-99 plain, 100-199 inverted, negatives add 100
// - four selectors: three general outputs, alarm relay
// - codes 33/133: ready after flux or start
// - codes 34/134: speed at or below low threshold
// - codes 35/135: torque above torque threshold
// - codes 36/136: position reached indication
// - codes 39/139: start-time tuning completed
// - codes 40/140: data trace completed
// - codes 41-43: feedback speed above own thresholds
// - in V/F mode feedback flags follow speed detect
// - running two: start on, or decelerating after
// - running two off with only pre-excite command
// - running two on while orientation command active
// - position control: running two follows servo-on
// - codes 97/197; major stops stage now, minor after stop
// - codes 98/198: fan fault or comm error
// - codes 99/199: alarm on major fault trip
`ifndef DSOS_CFG_SVH
`define DSOS_CFG_SVH

`define DSOS_OFS_SEL0 8'h00
`define DSOS_OFS_CTRL 8'h10
`define DSOS_OFS_THR_LOW 8'h14
`define DSOS_OFS_THR_TRQ 8'h18
`define DSOS_OFS_THR_FBK0 8'h1C
`define DSOS_OFS_FLAGS 8'h28
`define DSOS_OFS_IRQ_ST 8'h2C
`define DSOS_OFS_IRQ_MASK 8'h30

`define DSOS_CTRL_VF_BIT 0
`define DSOS_CTRL_POS_BIT 1

`define DSOS_RST_SEL_GEN 8'h00
`define DSOS_RST_SEL_ALARM 8'h63
`define DSOS_RST_THR 16'h0000
`define DSOS_RST_CTRL 2'h0
`define DSOS_RST_MASK 8'h00

`define DSOS_NEG_BASE 8'h64
`define DSOS_CODE_MAX 8'hC7
`define DSOS_CODE_READY_FLUX 8'h21
`define DSOS_CODE_LOW_SPEED 8'h22
`define DSOS_CODE_TORQUE 8'h23
`define DSOS_CODE_POSITION 8'h24
`define DSOS_CODE_TUNING 8'h27
`define DSOS_CODE_TRACE 8'h28
`define DSOS_CODE_FBK0 8'h29
`define DSOS_CODE_FBK1 8'h2A
`define DSOS_CODE_FBK2 8'h2B
`define DSOS_CODE_RUN_TWO 8'h2C
`define DSOS_CODE_MINOR_STOP 8'h61
`define DSOS_CODE_LIGHT 8'h62
`define DSOS_CODE_ALARM 8'h63

`define DSOS_RESP_OKAY 2'h0
`define DSOS_RESP_SLVERR 2'h2

`endif

// ---- verilog/dsos_pkg.sv ----
// types shared by the drive status output selector
package dsos_pkg;
	typedef struct packed {
		logic [3:0][7:0] sel;
		logic [1:0] ctrl;
		logic [15:0] thr_low;
		logic [15:0] thr_trq;
		logic [2:0][15:0] thr_fbk;
		logic [7:0] irq_st;
		logic [7:0] irq_mask;
		logic [7:0] ev_prev;
		logic minor_off;
		logic gate_en;
		logic irq;
		logic [3:0] term;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} dsos_state_t;
endpackage : dsos_pkg

// ---- verilog/dsos_top.sv ----
// drive status output selector: flag mux, polarity, registers
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`include "dsos_cfg.svh"

module dsos_top
	import dsos_pkg::*;
#(
	parameter int SPEED_W = 16 // width of speed and torque words
) (
	input wire logic aclk, // control clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic [SPEED_W-1:0] speed_feedback, // measured speed
	input wire logic [SPEED_W-1:0] motor_torque, // measured torque
	input wire logic [2:0] output_speed_detect, // V/F speed detectors
	input wire logic preexcite_enabled, // drive uses pre-excitation
	input wire logic preexcite_finished, // pre-excitation complete
	input wire logic output_active, // drive output started
	input wire logic position_reached_flag, // in-position
	input wire logic tuning_done_flag, // start-time tuning complete
	input wire logic trace_done_flag, // data trace complete
	input wire logic start_forward, // forward start signal
	input wire logic start_reverse, // reverse start signal
	input wire logic decelerating, // ramping down after start off
	input wire logic preexcite_command, // pre-excite / servo-on
	input wire logic orientation_command, // orientation input
	input wire logic fan_fault, // cooling fan fault
	input wire logic comm_error, // communication error alarm
	input wire logic minor_fault, // stop-after-decel fault
	input wire logic major_fault, // protective trip
	input wire logic motor_stopped, // speed reached standstill
	output logic general_output_one, // terminal 1
	output logic general_output_two, // terminal 2
	output logic general_output_three, // terminal 3
	output logic alarm_relay_output, // alarm relay terminal
	output logic power_stage_enable, // power stage gate enable
	output logic irq // level interrupt
);

	dsos_state_t st;
	dsos_state_t next_st;

	logic ready_after_flux;
	logic low_speed_flag;
	logic torque_over_flag;
	logic [2:0] feedback_speed;
	logic running_flag_two;
	logic light_fault_flag;
	logic minor_stop_fault_flag;
	logic [7:0] events;
	logic [3:0] term_flag;
	logic vf_mode;
	logic pos_mode;

	assign vf_mode = st.ctrl[`DSOS_CTRL_VF_BIT];
	assign pos_mode = st.ctrl[`DSOS_CTRL_POS_BIT];

	// flag sources
	always_comb begin
		ready_after_flux = preexcite_enabled ? preexcite_finished : output_active;
		low_speed_flag = (speed_feedback <= st.thr_low);
		torque_over_flag = (motor_torque > st.thr_trq);
		// speed mode: start/decel/orientation terms only; position mode: pre-excite command alone
		if (pos_mode) begin
			running_flag_two = preexcite_command;
		end else begin
			running_flag_two = start_forward | start_reverse | decelerating
				| orientation_command;
		end
		light_fault_flag = fan_fault | comm_error;
		minor_stop_fault_flag = minor_fault;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_fbk
			assign feedback_speed[gi] = vf_mode ? output_speed_detect[gi]
				: (speed_feedback > st.thr_fbk[gi]);
		end
	endgenerate

	assign events = {low_speed_flag, torque_over_flag, position_reached_flag, tuning_done_flag,
		trace_done_flag, minor_stop_fault_flag, light_fault_flag, major_fault};

	function automatic logic flag_of(input logic [7:0] code);
		logic [7:0] base;
		logic f;
		base = (code >= `DSOS_NEG_BASE) ? code - `DSOS_NEG_BASE : code;
		f = 1'b0;
		case (base)
			`DSOS_CODE_READY_FLUX: f = ready_after_flux;
			`DSOS_CODE_LOW_SPEED: f = low_speed_flag;
			`DSOS_CODE_TORQUE: f = torque_over_flag;
			`DSOS_CODE_POSITION: f = position_reached_flag;
			`DSOS_CODE_TUNING: f = tuning_done_flag;
			`DSOS_CODE_TRACE: f = trace_done_flag;
			`DSOS_CODE_FBK0: f = feedback_speed[0];
			`DSOS_CODE_FBK1: f = feedback_speed[1];
			`DSOS_CODE_FBK2: f = feedback_speed[2];
			`DSOS_CODE_RUN_TWO: f = running_flag_two;
			`DSOS_CODE_MINOR_STOP: f = minor_stop_fault_flag;
			`DSOS_CODE_LIGHT: f = light_fault_flag;
			`DSOS_CODE_ALARM: f = major_fault;
			default: f = 1'b0;
		endcase
		// inverted half of the code space
		return (code >= `DSOS_NEG_BASE) ? ~f : f;
	endfunction : flag_of

	// a negative word folds onto the inverted range; out of range writes are ignored
	function automatic logic [8:0] decode_sel(input logic [31:0] v);
		logic [31:0] mag;
		logic [8:0] r;
		mag = -v;
		r = 9'h000;
		if (v[31]) begin
			if (mag < 32'h0000_0064) begin
				r = {1'b1, mag[7:0] + `DSOS_NEG_BASE};
			end
		end else if (v <= 32'h0000_00C7) begin
			r = {1'b1, v[7:0]};
		end
		return r;
	endfunction : decode_sel

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	generate
		for (gi = 0; gi < 4; gi++) begin : g_term
			// flag_of reads the flag nets directly, so a process must track them
			always_comb begin
				term_flag[gi] = flag_of(st.sel[gi]);
			end
		end
	endgenerate

	logic wr_go;
	logic rd_go;
	logic [5:0] wr_idx;
	logic [5:0] rd_idx;
	assign wr_go = st.awready & s_axi_awvalid & st.wready & s_axi_wvalid;
	assign rd_go = st.arready & s_axi_arvalid;
	assign wr_idx = s_axi_awaddr[7:2];
	assign rd_idx = s_axi_araddr[7:2];

	always_comb begin
		logic [31:0] cur;
		logic [31:0] wv;
		logic [8:0] dec;
		logic rd_clear;
		cur = 32'h0000_0000;
		wv = 32'h0000_0000;
		dec = 9'h000;
		rd_clear = 1'b0;
		next_st = st;

		next_st.term = term_flag;
		// major trips at once; minor waits for standstill, then holds off
		next_st.minor_off = minor_fault & (motor_stopped | st.minor_off);
		next_st.gate_en = ~major_fault & ~(minor_fault & (motor_stopped | st.minor_off));
		next_st.ev_prev = events;

		// address and data are taken together, one write in flight
		next_st.awready = ~st.awready & ~st.bvalid & s_axi_awvalid & s_axi_wvalid;
		next_st.wready = ~st.wready & ~st.bvalid & s_axi_awvalid & s_axi_wvalid;
		if (st.bvalid & s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (wr_go) begin
			next_st.awready = 1'b0;
			next_st.wready = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = `DSOS_RESP_OKAY;
			case ({wr_idx, 2'b00})
				`DSOS_OFS_SEL0, `DSOS_OFS_SEL0 + 8'h04, `DSOS_OFS_SEL0 + 8'h08,
				`DSOS_OFS_SEL0 + 8'h0C: begin
					wv = merge({24'h00_0000, st.sel[wr_idx[1:0]]}, s_axi_wdata, s_axi_wstrb);
					if (s_axi_wstrb != 4'hF) begin
						wv = {24'h00_0000, wv[7:0]};
					end
					dec = decode_sel(wv);
					if (dec[8]) begin
						next_st.sel[wr_idx[1:0]] = dec[7:0];
					end
				end
				`DSOS_OFS_CTRL: next_st.ctrl = s_axi_wstrb[0] ? s_axi_wdata[1:0] : st.ctrl;
				`DSOS_OFS_THR_LOW: begin
					wv = merge({16'h0000, st.thr_low}, s_axi_wdata, s_axi_wstrb);
					next_st.thr_low = wv[15:0];
				end
				`DSOS_OFS_THR_TRQ: begin
					wv = merge({16'h0000, st.thr_trq}, s_axi_wdata, s_axi_wstrb);
					next_st.thr_trq = wv[15:0];
				end
				`DSOS_OFS_THR_FBK0, `DSOS_OFS_THR_FBK0 + 8'h04, `DSOS_OFS_THR_FBK0 + 8'h08: begin
					wv = merge({16'h0000, st.thr_fbk[wr_idx - 6'h07]}, s_axi_wdata, s_axi_wstrb);
					next_st.thr_fbk[wr_idx - 6'h07] = wv[15:0];
				end
				`DSOS_OFS_IRQ_MASK: begin
					next_st.irq_mask = s_axi_wstrb[0] ? s_axi_wdata[7:0] : st.irq_mask;
				end
				`DSOS_OFS_FLAGS, `DSOS_OFS_IRQ_ST: ;
				default: next_st.bresp = `DSOS_RESP_SLVERR;
			endcase
		end

		next_st.arready = ~st.arready & ~st.rvalid & s_axi_arvalid;
		if (st.rvalid & s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (rd_go) begin
			next_st.arready = 1'b0;
			next_st.rvalid = 1'b1;
			next_st.rresp = `DSOS_RESP_OKAY;
			case ({rd_idx, 2'b00})
				`DSOS_OFS_SEL0, `DSOS_OFS_SEL0 + 8'h04, `DSOS_OFS_SEL0 + 8'h08,
				`DSOS_OFS_SEL0 + 8'h0C: cur = {24'h00_0000, st.sel[rd_idx[1:0]]};
				`DSOS_OFS_CTRL: cur = {30'h0000_0000, st.ctrl};
				`DSOS_OFS_THR_LOW: cur = {16'h0000, st.thr_low};
				`DSOS_OFS_THR_TRQ: cur = {16'h0000, st.thr_trq};
				`DSOS_OFS_THR_FBK0, `DSOS_OFS_THR_FBK0 + 8'h04, `DSOS_OFS_THR_FBK0 + 8'h08:
					cur = {16'h0000, st.thr_fbk[rd_idx - 6'h07]};
				`DSOS_OFS_FLAGS: cur = {14'h0000, running_flag_two, feedback_speed,
					ready_after_flux, st.gate_en, st.term, events};
				`DSOS_OFS_IRQ_ST: begin
					cur = {24'h00_0000, st.irq_st};
					rd_clear = 1'b1;
				end
				`DSOS_OFS_IRQ_MASK: cur = {24'h00_0000, st.irq_mask};
				default: next_st.rresp = `DSOS_RESP_SLVERR;
			endcase
			next_st.rdata = cur;
		end

		// a new rising edge in the clearing cycle still lands
		next_st.irq_st = (rd_clear ? 8'h00 : st.irq_st) | (events & ~st.ev_prev);
		next_st.irq = |(next_st.irq_st & next_st.irq_mask);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			st.sel[0] <= `DSOS_RST_SEL_GEN;
			st.sel[1] <= `DSOS_RST_SEL_GEN;
			st.sel[2] <= `DSOS_RST_SEL_GEN;
			st.sel[3] <= `DSOS_RST_SEL_ALARM;
			st.ctrl <= `DSOS_RST_CTRL;
			st.thr_low <= `DSOS_RST_THR;
			st.thr_trq <= `DSOS_RST_THR;
			st.thr_fbk <= '0;
			st.irq_mask <= `DSOS_RST_MASK;
		end else begin
			st <= next_st;
		end
	end

	assign general_output_one = st.term[0];
	assign general_output_two = st.term[1];
	assign general_output_three = st.term[2];
	assign alarm_relay_output = st.term[3];
	assign power_stage_enable = st.gate_en;
	assign irq = st.irq;
	assign s_axi_awready = st.awready;
	assign s_axi_wready = st.wready;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = st.arready;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rresp = st.rresp;
	assign s_axi_rdata = st.rdata;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_plain;
		(st.sel[0] < `DSOS_NEG_BASE) |=> (general_output_one == $past(term_flag[0]));
	endproperty
	a_plain: assert property (p_plain) else $error("plain code mismatch");

	property p_inv;
		(st.sel[1] == 8'h90) |=> (general_output_two == ~$past(running_flag_two));
	endproperty
	a_inv: assert property (p_inv) else $error("inverted running flag wrong");

	property p_ready;
		(!preexcite_enabled && output_active) |-> ready_after_flux;
	endproperty
	a_ready: assert property (p_ready) else $error("ready flag missing");

	property p_low;
		(speed_feedback <= st.thr_low) |-> low_speed_flag;
	endproperty
	a_low: assert property (p_low) else $error("low speed flag missing");

	property p_trq;
		torque_over_flag |-> (motor_torque > st.thr_trq);
	endproperty
	a_trq: assert property (p_trq) else $error("torque flag spurious");

	property p_vf;
		vf_mode |-> (feedback_speed == output_speed_detect);
	endproperty
	a_vf: assert property (p_vf) else $error("V/F speed flags differ");

	property p_lxonly;
		(!pos_mode && preexcite_command && !start_forward && !start_reverse
			&& !decelerating && !orientation_command) |-> !running_flag_two;
	endproperty
	a_lxonly: assert property (p_lxonly) else $error("running on pre-excite");

	property p_orient;
		(!pos_mode && orientation_command) |-> running_flag_two;
	endproperty
	a_orient: assert property (p_orient) else $error("running off on orientation");

	property p_servo;
		pos_mode |-> (running_flag_two == preexcite_command);
	endproperty
	a_servo: assert property (p_servo) else $error("running not servo-on");

	property p_major;
		major_fault |=> !power_stage_enable;
	endproperty
	a_major: assert property (p_major) else $error("stage not cut on trip");

	property p_minor;
		(minor_fault && !major_fault && !motor_stopped && !st.minor_off) |=> power_stage_enable;
	endproperty
	a_minor: assert property (p_minor) else $error("stage cut before stop");

	property p_alarm;
		(st.sel[3] == `DSOS_CODE_ALARM && major_fault) |=> alarm_relay_output;
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm relay not set");

	property p_light;
		(fan_fault || comm_error) |-> light_fault_flag;
	endproperty
	a_light: assert property (p_light) else $error("light fault missing");

	property p_fbk;
		(!vf_mode && speed_feedback > st.thr_fbk[0]) |-> feedback_speed[0];
	endproperty
	a_fbk: assert property (p_fbk) else $error("feedback speed flag missing");

	property p_run;
		(!pos_mode && (start_forward || start_reverse || decelerating)) |-> running_flag_two;
	endproperty
	a_run: assert property (p_run) else $error("running flag two missing");

	property p_restore;
		(!major_fault && !minor_fault) |=> power_stage_enable;
	endproperty
	a_restore: assert property (p_restore) else $error("stage not restored");

endmodule : dsos_top

// ---- sim/dsos_relay_model.sv ----
// relay coils hanging on the four output terminals
module dsos_relay_model (
	input wire logic aclk, // control clock
	input wire logic [3:0] coil, // terminal levels: one, two, three, relay
	output logic [3:0] contact // contact state, one cycle behind the coil
);
	timeunit 1ns;
	timeprecision 1ps;
	// a coil takes a clock to pull in; no bounce modelled
	always_ff @(posedge aclk) begin
		contact <= coil;
	end
endmodule : dsos_relay_model

// ---- sim/tb_top.sv ----
// self-checking bench for the drive status output selector
`include "dsos_cfg.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} dsos_rexp_t;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, pse, irq;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp, ctrl;
	logic [15:0] speed, torque, in_b;
	logic [15:0] thr [5];
	logic [2:0] osd;
	logic [3:0] term, contact;
	dsos_rexp_t rq[$];
	logic [1:0] wq[$];
	int err_total, checks, cyc;
	int codes[13] = '{33, 34, 35, 36, 39, 40, 41, 42, 43, 44, 97, 98, 99};
	dsos_top dsos_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .speed_feedback(speed), .motor_torque(torque),
		.output_speed_detect(osd), .preexcite_enabled(in_b[0]),
		.preexcite_finished(in_b[1]), .output_active(in_b[2]),
		.position_reached_flag(in_b[3]), .tuning_done_flag(in_b[4]),
		.trace_done_flag(in_b[5]), .start_forward(in_b[6]), .start_reverse(in_b[7]),
		.decelerating(in_b[8]), .preexcite_command(in_b[9]),
		.orientation_command(in_b[10]), .fan_fault(in_b[11]), .comm_error(in_b[12]),
		.minor_fault(in_b[13]), .major_fault(in_b[14]), .motor_stopped(in_b[15]),
		.general_output_one(term[3]), .general_output_two(term[2]),
		.general_output_three(term[1]), .alarm_relay_output(term[0]),
		.power_stage_enable(pse), .irq(irq));
	dsos_relay_model dsos_relay_model_i (.aclk(aclk), .coil(term), .contact(contact));
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task stop_test;
		if (err_total == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test
	// the watcher side: every completed response is matched to the oldest note
	always @(posedge aclk) begin
		dsos_rexp_t e;
		cyc++;
		if (bvalid && bready && wq.size() > 0) begin
			check(32'(bresp), 32'(wq.pop_front()));
		end
		if (rvalid && rready && rq.size() > 0) begin
			e = rq.pop_front();
			check(rdata & e.m, e.d);
			check(32'(rresp), 32'(e.r));
		end
		if (cyc == 20000) begin
			err_total++;
			stop_test;
		end
	end
	task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic at, dt;
		wq.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		at = 1'b0;
		dt = 1'b0;
		while (!(at && dt)) begin
			@(posedge aclk);
			if (awready) begin
				awvalid <= 1'b0;
				at = 1'b1;
			end
			if (wready) begin
				wvalid <= 1'b0;
				dt = 1'b1;
			end
		end
		do @(posedge aclk); while (!bvalid);
	endtask : axi_wr
	task axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
			input logic [1:0] r);
		rq.push_back('{d & m, m, r});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
	endtask : axi_rd
	function automatic logic flag_of(int c);
		case (c)
			33: return in_b[0] ? in_b[1] : in_b[2];
			34: return speed <= thr[0];
			35: return torque > thr[1];
			36: return in_b[3];
			39: return in_b[4];
			40: return in_b[5];
			41, 42, 43: return ctrl[0] ? osd[c-41] : speed > thr[c-39];
			44: return ctrl[1] ? in_b[9] : |{in_b[6], in_b[7], in_b[8], in_b[10]};
			97: return in_b[13];
			98: return in_b[11] | in_b[12];
			99: return in_b[14];
			default: return 1'b0;
		endcase
	endfunction : flag_of
	task wait_cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : wait_cyc
	initial begin
		logic f;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, speed, torque, in_b, osd, ctrl} = '0;
		void'($urandom(32'h8d70));
		wait_cyc(20);
		aresetn <= 1'b1;
		wait_cyc(1);
		// reset contents: selections 0,0,0,99, control, thresholds and mask zero
		for (int i = 0; i < 13; i++) begin
			if (i != 10 && i != 11) begin
				axi_rd(8'(4 * i), (i == 3) ? 32'h0000_0063 : 32'h0000_0000, '1,
					`DSOS_RESP_OKAY);
			end
		end
		for (int k = 0; k < 39; k++) begin
			ctrl = 2'($urandom);
			for (int t = 0; t < 5; t++) thr[t] = 16'($urandom % 4);
			axi_wr(`DSOS_OFS_CTRL, 32'(ctrl), `DSOS_RESP_OKAY);
			for (int t = 0; t < 5; t++) axi_wr(8'(8'h14 + 4 * t), 32'(thr[t]), `DSOS_RESP_OKAY);
			axi_wr(8'h00, 32'(codes[k % 13]), `DSOS_RESP_OKAY);
			axi_wr(8'h04, 32'(codes[k % 13] + 100), `DSOS_RESP_OKAY);
			// negative codes need all four strobes
			axi_wr(8'h08, 32'(-codes[k % 13]), `DSOS_RESP_OKAY);
			axi_wr(8'h0C, 32'(codes[k % 13]), `DSOS_RESP_OKAY);
			axi_rd(8'h08, 32'(codes[k % 13] + 100), '1, `DSOS_RESP_OKAY);
			in_b <= 16'($urandom);
			speed <= 16'($urandom % 4);
			torque <= 16'($urandom % 4);
			osd <= 3'($urandom);
			wait_cyc(3);
			f = flag_of(codes[k % 13]);
			check(32'(term), 32'({f, ~f, ~f, f}));
			check(32'(contact), 32'({f, ~f, ~f, f}));
		end
		// only the pre-excite command, speed mode: running flag two stays low
		axi_wr(`DSOS_OFS_CTRL, 32'h0000_0000, `DSOS_RESP_OKAY);
		axi_wr(8'h00, 32'd44, `DSOS_RESP_OKAY);
		in_b <= 16'h0200;
		wait_cyc(3);
		check(32'(term[3]), 32'h0000_0000);
		in_b <= 16'h0400;
		wait_cyc(1);
		check(32'(term[3]), 32'h0000_0000);
		wait_cyc(1);
		check(32'(term[3]), 32'h0000_0001);
		// refused accesses
		axi_wr(8'h00, 32'd200, `DSOS_RESP_OKAY);
		axi_rd(8'h00, 32'd44, '1, `DSOS_RESP_OKAY);
		axi_wr(8'h40, 32'h0000_0055, `DSOS_RESP_SLVERR);
		axi_rd(8'h40, 32'h0000_0000, '1, `DSOS_RESP_SLVERR);
		// power stage on major and minor faults
		in_b <= 16'h0000;
		wait_cyc(3);
		check(32'(pse), 32'h0000_0001);
		in_b <= 16'h4000;
		wait_cyc(2);
		check(32'(pse), 32'h0000_0000);
		check(32'(term[0]), 32'h0000_0001);
		in_b <= 16'h2000;
		wait_cyc(3);
		check(32'(pse), 32'h0000_0001);
		in_b <= 16'hA000;
		wait_cyc(2);
		check(32'(pse), 32'h0000_0000);
		in_b <= 16'h2000;
		wait_cyc(3);
		check(32'(pse), 32'h0000_0000);
		in_b <= 16'h0000;
		wait_cyc(3);
		check(32'(pse), 32'h0000_0001);
		// interrupt: clear, enable light fault only, raise major, enable major only, then raise light fault
		axi_rd(`DSOS_OFS_IRQ_ST, 32'h0000_0000, 32'h0000_0000, `DSOS_RESP_OKAY);
		axi_wr(`DSOS_OFS_IRQ_MASK, 32'h0000_0002, `DSOS_RESP_OKAY);
		in_b <= 16'h4000;
		wait_cyc(3);
		check(32'(irq), 32'h0000_0000);
		axi_wr(`DSOS_OFS_IRQ_MASK, 32'h0000_0001, `DSOS_RESP_OKAY);
		wait_cyc(2);
		check(32'(irq), 32'h0000_0001);
		in_b <= 16'h4800;
		wait_cyc(2);
		axi_rd(`DSOS_OFS_IRQ_ST, 32'h0000_0003, 32'h0000_00FF, `DSOS_RESP_OKAY);
		wait_cyc(2);
		check(32'(irq), 32'h0000_0000);
		axi_rd(`DSOS_OFS_IRQ_ST, 32'h0000_0000, 32'h0000_00FF, `DSOS_RESP_OKAY);
		wait_cyc(4);
		stop_test;
	end
endmodule : tb_top
